// File: inc/scrc_pkg.sv
package scrc_pkg;
  // ----------------------------------------
  // Halt mode encoding
  // ----------------------------------------
  typedef enum logic [1:0] {
    SCRC_MODE_RUN = 2'b00,
    SCRC_MODE_IDLE_LIGHT = 2'b01,
    SCRC_MODE_IDLE_DEEP = 2'b10,
    SCRC_MODE_STOP = 2'b11
  } scrc_mode_e;

  // ----------------------------------------
  // Timing constants
  // ----------------------------------------
  // Oscillator settling count in stop mode, two to the fourteenth
  localparam int SCRC_SETTLE_CYCLES = 16384;
  // Restart delay of 2.5 periods, rounded up to whole cycles
  localparam real SCRC_RESTART_PERIODS = 2.5;
  localparam int SCRC_RESTART_CYCLES = 3;
  // Least reset hold, in clock periods
  localparam int SCRC_RESET_HOLD_CYCLES = 3;
  // Extra wait states inserted by the device itself
  localparam int SCRC_AUTO_WAIT_CYCLES = 1;
  localparam int SCRC_CNT_W = 16;
  localparam logic [SCRC_CNT_W-1:0] SCRC_CNT_RESET = 16'h0000;
endpackage : scrc_pkg

// File: inc/scrc_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
// Synchronised event levels passed from the input stage to the control
interface scrc_sync_if;
  logic int_req;
  logic nmi_req;
  logic rst_req;
  modport src (output int_req, output nmi_req, output rst_req);
  modport dst (input int_req, input nmi_req, input rst_req);
endinterface : scrc_sync_if
`default_nettype wire

// File: hw/scrc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module scrc_sync (
  input wire logic core_clk, // Core clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic clk_en, // Clock enable
  input wire logic int_n, // Maskable interrupt pin, active low
  input wire logic nmi_n, // Non-maskable interrupt pin, active low
  input wire logic reset_n, // Reset pin, active low
  scrc_sync_if.src sy // Synchronised levels
);
  // ----------------------------------------
  // Two-stage synchronisers, idle levels high
  // ----------------------------------------
  logic [2:0] s1_r;
  logic [2:0] s2_r;

  // Pins pass two flops before any logic reads them
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s1_r <= 3'h7;
      s2_r <= 3'h7;
    end else if (clk_en) begin
      s1_r <= {reset_n, nmi_n, int_n};
      s2_r <= s1_r;
    end
  end

  // Active-high requests
  assign sy.int_req = ~s2_r[0];
  assign sy.nmi_req = ~s2_r[1];
  assign sy.rst_req = ~s2_r[2];
endmodule : scrc_sync
`default_nettype wire

// File: hw/scrc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module scrc_ctrl #(
  parameter int SETTLE_CYCLES = scrc_pkg::SCRC_SETTLE_CYCLES // Stop-mode settling count
) (
  input wire logic core_clk, // Core clock, 125 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic clk_en, // Clock enable, freezes all state when low except the core-reset clear of state and count
  input wire logic int_n, // Maskable interrupt pin, active low
  input wire logic nmi_n, // Non-maskable interrupt pin, active low
  input wire logic reset_n, // External reset pin, active low
  input wire logic [1:0] mode_sel, // Halt mode chosen before halting
  input wire logic halt_req, // Core executes halt, one-cycle pulse
  input wire logic int_enabled, // Core would accept a maskable interrupt
  input wire logic wait_cycle, // Core enters the cycle needing a wait, pulse
  output logic sys_clk_en, // Internal system clock gate
  output logic osc_en, // Oscillator running
  output logic halted, // Halt state indicator
  output logic filler_no_operation, // Core executes filler instruction
  output logic auto_wait_state, // Automatic wait state, one cycle
  output logic int_take, // Maskable interrupt accepted, pulse
  output logic nmi_take, // Non-maskable interrupt accepted, pulse
  output logic core_reset // Reset to the core
);
  // Refuse settling counts that the cycle counter cannot hold
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_bad_settle
    $error("SETTLE_CYCLES out of range");
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  scrc_sync_if sy ();

  scrc_sync u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .int_n(int_n),
    .nmi_n(nmi_n),
    .reset_n(reset_n),
    .sy(sy)
  );

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  typedef enum logic [2:0] {
    SCRC_ST_RUN = 3'b000,
    SCRC_ST_HALT_RUN = 3'b001,
    SCRC_ST_GATED = 3'b010,
    SCRC_ST_SETTLE = 3'b011,
    SCRC_ST_RESTART = 3'b100,
    SCRC_ST_FILLER = 3'b101
  } scrc_state_e;

  scrc_state_e state_r;
  scrc_state_e state_nxt;
  logic [scrc_pkg::SCRC_CNT_W-1:0] cnt_r;
  logic [scrc_pkg::SCRC_CNT_W-1:0] cnt_nxt;
  logic [1:0] mode_r;
  logic nmi_d_r;
  logic [1:0] rst_cnt_r;
  logic rst_hold_r;
  logic wait_r;
  logic int_take_r;
  logic nmi_take_r;

  localparam logic [scrc_pkg::SCRC_CNT_W-1:0] SETTLE_LAST =
    scrc_pkg::SCRC_CNT_W'(SETTLE_CYCLES - 1);
  localparam logic [scrc_pkg::SCRC_CNT_W-1:0] RESTART_LAST =
    scrc_pkg::SCRC_CNT_W'(scrc_pkg::SCRC_RESTART_CYCLES - 1);
  localparam logic [1:0] RST_HOLD_LAST = 2'(scrc_pkg::SCRC_RESET_HOLD_CYCLES - 1);

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  // Non-maskable input is edge triggered, maskable is level
  wire nmi_edge = sy.nmi_req & ~nmi_d_r;
  wire wake_int = sy.int_req & int_enabled;
  wire wake_any = wake_int | nmi_edge;
  wire mode_stop = (mode_r == scrc_pkg::SCRC_MODE_STOP);
  wire mode_run = (mode_r == scrc_pkg::SCRC_MODE_RUN);
  wire cnt_done_settle = (cnt_r == SETTLE_LAST);
  wire cnt_done_restart = (cnt_r == RESTART_LAST);
  // Acceptance only counts while the filler instruction runs
  wire accept_int = filler_no_operation & sy.int_req & int_enabled;
  // A held low level only counts in the restart filler, never in a run-mode halt
  wire accept_nmi = filler_no_operation &
                    (nmi_edge | (nmi_d_r & (state_r == SCRC_ST_FILLER)));
  wire accept = accept_int | accept_nmi;

  // Next-state logic
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      SCRC_ST_RUN: begin
        if (halt_req) begin
          // Run mode keeps the clock, other modes gate it
          state_nxt = (mode_sel == scrc_pkg::SCRC_MODE_RUN) ? SCRC_ST_HALT_RUN
                                                             : SCRC_ST_GATED;
        end
      end
      SCRC_ST_HALT_RUN: begin
        if (sy.int_req & int_enabled | nmi_edge) begin
          state_nxt = SCRC_ST_RUN;
        end
      end
      SCRC_ST_GATED: begin
        if (wake_any) begin
          cnt_nxt = scrc_pkg::SCRC_CNT_RESET;
          state_nxt = mode_stop ? SCRC_ST_SETTLE : SCRC_ST_RESTART;
        end
      end
      SCRC_ST_SETTLE: begin
        if (cnt_done_settle) begin
          cnt_nxt = scrc_pkg::SCRC_CNT_RESET;
          state_nxt = SCRC_ST_RESTART;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      SCRC_ST_RESTART: begin
        if (cnt_done_restart) begin
          state_nxt = SCRC_ST_FILLER;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      SCRC_ST_FILLER: begin
        // Not accepted during filler: clock stops again
        state_nxt = accept ? SCRC_ST_RUN : SCRC_ST_GATED;
      end
      default: begin
        state_nxt = SCRC_ST_RUN;
      end
    endcase
  end

  // State register; synchronous reset or core reset forces run
  always_ff @(posedge core_clk) begin
    if (reset || rst_hold_r) begin
      state_r <= SCRC_ST_RUN;
      cnt_r <= scrc_pkg::SCRC_CNT_RESET;
    end else if (clk_en) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Latch halt mode at halt entry
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_r <= scrc_pkg::SCRC_MODE_RUN;
      nmi_d_r <= 1'b0;
    end else if (clk_en) begin
      nmi_d_r <= sy.nmi_req;
      if (state_r == SCRC_ST_RUN && halt_req) begin
        mode_r <= mode_sel;
      end
    end
  end

  // ----------------------------------------
  // Reset qualification
  // ----------------------------------------
  // Reset pin must stay low three clocks to reset the core
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rst_cnt_r <= 2'h0;
      rst_hold_r <= 1'b0;
    end else if (clk_en) begin
      if (!sy.rst_req) begin
        rst_cnt_r <= 2'h0;
        rst_hold_r <= 1'b0;
      end else if (rst_cnt_r != RST_HOLD_LAST) begin
        rst_cnt_r <= rst_cnt_r + 2'h1;
      end else begin
        rst_hold_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Wait state and acceptance pulses
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wait_r <= 1'b0;
      int_take_r <= 1'b0;
      nmi_take_r <= 1'b0;
    end else if (clk_en) begin
      wait_r <= wait_cycle & (state_r == SCRC_ST_RUN);
      int_take_r <= accept_int & ~accept_nmi;
      nmi_take_r <= accept_nmi;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign sys_clk_en = (state_r == SCRC_ST_RUN) || (state_r == SCRC_ST_HALT_RUN) ||
                      (state_r == SCRC_ST_FILLER);
  assign osc_en = !((state_r == SCRC_ST_GATED) && mode_stop);
  assign halted = (state_r != SCRC_ST_RUN);
  assign filler_no_operation = (state_r == SCRC_ST_HALT_RUN) || (state_r == SCRC_ST_FILLER);
  assign auto_wait_state = wait_r;
  assign int_take = int_take_r;
  assign nmi_take = nmi_take_r;
  assign core_reset = rst_hold_r;

  wire unused_ok = mode_run;
endmodule : scrc_ctrl
`default_nettype wire

// File: testbench/scrc_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks for halt, restart and wait behaviour
module scrc_ctrl_checker #(
  parameter int SETTLE_CYCLES = scrc_pkg::SCRC_SETTLE_CYCLES // Settling count
) (
  input wire logic core_clk, // Core clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic [1:0] mode_sel, // Halt mode at halt entry
  input wire logic halt_req, // Halt pulse from the core
  input wire logic int_enabled, // Core accepts maskable requests
  input wire logic wait_cycle, // Cycle needing the wait state
  input wire logic sys_clk_en, // System clock gate
  input wire logic osc_en, // Oscillator running
  input wire logic halted, // Halt state
  input wire logic filler_no_operation, // Filler instruction runs
  input wire logic auto_wait_state, // Automatic wait state
  input wire logic int_take, // Maskable acceptance pulse
  input wire logic nmi_take // Non-maskable acceptance pulse
);
  // Oscillator restart to clock restart: settling plus restart cycles
  localparam logic [31:0] STOP_SPAN = 32'(SETTLE_CYCLES + scrc_pkg::SCRC_RESTART_CYCLES);
  logic stop_wake_r;
  logic [31:0] stop_cnt_r;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Counts cycles from the oscillator's return until the clock runs again
  always_ff @(posedge core_clk) begin
    if (reset || sys_clk_en) begin
      stop_wake_r <= 1'b0;
      stop_cnt_r <= 32'h00000000;
    end else if (!osc_en) begin
      stop_wake_r <= 1'b1;
      stop_cnt_r <= 32'h00000000;
    end else if (stop_wake_r) begin
      stop_cnt_r <= stop_cnt_r + 32'h00000001;
    end
  end

  // Halt entry per mode
  property p_halt_run;
    halt_req && !halted && mode_sel == 2'h0 |=> halted && sys_clk_en && filler_no_operation;
  endproperty
  a_halt_run: assert property (p_halt_run) else $error("run halt bad");
  property p_halt_gate;
    halt_req && !halted && mode_sel inside {2'h1, 2'h2} |=> !sys_clk_en && osc_en;
  endproperty
  a_halt_gate: assert property (p_halt_gate) else $error("idle gate bad");
  property p_stop_osc;
    halt_req && !halted && mode_sel == 2'h3 |=> !osc_en && !sys_clk_en;
  endproperty
  a_stop_osc: assert property (p_stop_osc) else $error("stop gate bad");
  // Restart timing and exit
  property p_stop_restart;
    $rose(sys_clk_en) && stop_wake_r |-> stop_cnt_r == STOP_SPAN;
  endproperty
  a_stop_restart: assert property (p_stop_restart) else $error("stop restart bad");
  property p_idle_restart;
    $rose(sys_clk_en) && halted |-> !$past(sys_clk_en, 3) && filler_no_operation;
  endproperty
  a_idle_restart: assert property (p_idle_restart) else $error("restart short");
  property p_leave;
    $rose(sys_clk_en) && halted ##1 !halted |-> int_take || nmi_take;
  endproperty
  a_leave: assert property (p_leave) else $error("exit without take");
  property p_take;
    int_take |-> $past(int_enabled) && !$past(int_take) && !halted;
  endproperty
  a_take: assert property (p_take) else $error("take bad");
  property p_wait;
    wait_cycle && !halted |=> auto_wait_state ##1 !auto_wait_state;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state bad");
endmodule : scrc_ctrl_checker
bind scrc_ctrl scrc_ctrl_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_chk (.*);
`default_nettype wire

// File: testbench/scrc_pin_src.sv
`timescale 1ns/1ps
`default_nettype none
// Peripherals and board reset driving the pins at falling edges
module scrc_pin_src (
  input wire logic core_clk, // Core clock
  output var logic int_n, // Maskable request
  output var logic nmi_n, // Non-maskable request
  output var logic reset_n // Board reset
);
  // Pins idle high until a scenario pulls them
  initial begin
    int_n = 1'b1;
    nmi_n = 1'b1;
    reset_n = 1'b1;
  end
  // Level changes for the request pins
  task automatic set_int(input logic lvl);
    @(negedge core_clk);
    int_n = lvl;
  endtask : set_int
  task automatic set_nmi(input logic lvl);
    @(negedge core_clk);
    nmi_n = lvl;
  endtask : set_nmi
  // Reset held low never under three clocks
  task automatic pulse_reset(input int n);
    @(negedge core_clk);
    reset_n = 1'b0;
    repeat ((n < 3) ? 3 : n) @(negedge core_clk);
    reset_n = 1'b1;
  endtask : pulse_reset
endmodule : scrc_pin_src
`default_nettype wire

// File: testbench/scrc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module scrc_ctrl_tb;
  localparam int SETTLE = 8;
  // Two synchroniser edges and the wake decision, then the restart count
  localparam int IDLE_EXP = 3 + scrc_pkg::SCRC_RESTART_CYCLES;
  logic core_clk = 1'b0;
  logic reset;
  logic clk_en;
  logic [1:0] mode_sel;
  logic halt_req;
  logic int_enabled;
  logic wait_cycle;
  logic int_n, nmi_n, reset_n, sys_clk_en, osc_en, halted, filler_no_operation;
  logic auto_wait_state, int_take, nmi_take, core_reset;
  int n_mismatch = 0;
  int n_checks = 0;
  int k;
  always #4 core_clk = ~core_clk;
  scrc_pin_src i_scrc_pin_src (.core_clk, .int_n, .nmi_n, .reset_n);
  scrc_ctrl #(.SETTLE_CYCLES(SETTLE)) i_scrc_ctrl (.core_clk, .reset, .clk_en(clk_en), .int_n,
    .nmi_n, .reset_n, .mode_sel, .halt_req, .int_enabled, .wait_cycle, .sys_clk_en, .osc_en,
    .halted, .filler_no_operation, .auto_wait_state, .int_take, .nmi_take, .core_reset);
  // Comparison and verdict
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  // Advances until halted falls, bounded
  task automatic leave_halt;
    for (k = 0; k < 100 && halted; k++) begin
      @(posedge core_clk);
      #1;
    end
  endtask : leave_halt
  // Halts, pulls a wake pin low, times the restart, then checks the take pulse at the exit
  task automatic halt_wake(input logic [1:0] m, input logic nmi, input int exp);
    @(negedge core_clk);
    mode_sel = m;
    halt_req = 1'b1;
    @(negedge core_clk);
    halt_req = 1'b0;
    if (nmi) i_scrc_pin_src.set_nmi(1'b0);
    else i_scrc_pin_src.set_int(1'b0);
    for (k = 0; k < 100 && !sys_clk_en; k++) begin
      @(posedge core_clk);
      #1;
    end
    check("restart", k, exp);
    leave_halt();
    check("take", nmi ? nmi_take : int_take, 1'b1);
    i_scrc_pin_src.set_nmi(1'b1);
    i_scrc_pin_src.set_int(1'b1);
    repeat (4) @(negedge core_clk);
  endtask : halt_wake
  task automatic t_idle;
    for (int m = 1; m < 3; m++) begin
      halt_wake(m[1:0], 1'b0, IDLE_EXP);
      halt_wake(m[1:0], 1'b1, IDLE_EXP);
    end
  endtask : t_idle
  task automatic t_stop;
    halt_wake(2'h3, 1'b0, IDLE_EXP + SETTLE);
    halt_wake(2'h3, 1'b1, IDLE_EXP + SETTLE);
  endtask : t_stop
  // Acceptance withdrawn after the wake: the clock stops again
  task automatic t_refuse;
    halt_wake(2'h1, 1'b0, IDLE_EXP);
    @(negedge core_clk);
    halt_req = 1'b1;
    @(negedge core_clk);
    halt_req = 1'b0;
    i_scrc_pin_src.set_int(1'b0);
    repeat (3) @(negedge core_clk);
    int_enabled = 1'b0;
    repeat (6) @(negedge core_clk);
    check("still_halted", {halted, sys_clk_en}, 2'h2);
    int_enabled = 1'b1;
    leave_halt();
    check("late_take", int_take, 1'b1);
    i_scrc_pin_src.set_int(1'b1);
    repeat (4) @(negedge core_clk);
  endtask : t_refuse
  // Run-mode halt keeps the clock and runs filler
  task automatic t_run;
    @(negedge core_clk);
    mode_sel = 2'h0;
    halt_req = 1'b1;
    @(negedge core_clk);
    halt_req = 1'b0;
    check("run_halt", {halted, sys_clk_en, filler_no_operation}, 3'h7);
    i_scrc_pin_src.set_int(1'b0);
    leave_halt();
    check("run_exit", halted, 1'b0);
    check("run_take", int_take, 1'b1);
    i_scrc_pin_src.set_int(1'b1);
    repeat (4) @(negedge core_clk);
  endtask : t_run
  // Clock enable low freezes an idle halt while a request waits
  task automatic t_freeze;
    @(negedge core_clk);
    mode_sel = 2'h1;
    halt_req = 1'b1;
    @(negedge core_clk);
    halt_req = 1'b0;
    clk_en = 1'b0;
    i_scrc_pin_src.set_int(1'b0);
    repeat (8) @(negedge core_clk);
    check("frozen", {halted, sys_clk_en}, 2'h2);
    clk_en = 1'b1;
    leave_halt();
    check("thaw_take", int_take, 1'b1);
    i_scrc_pin_src.set_int(1'b1);
    repeat (4) @(negedge core_clk);
  endtask : t_freeze
  // One automatic wait state, and a board reset pulse
  task automatic t_wait_reset;
    @(negedge core_clk);
    wait_cycle = 1'b1;
    @(negedge core_clk);
    wait_cycle = 1'b0;
    check("wait_on", auto_wait_state, 1'b1);
    @(negedge core_clk);
    check("wait_off", auto_wait_state, 1'b0);
    i_scrc_pin_src.pulse_reset(3);
    for (k = 0; k < 10 && !core_reset; k++) @(negedge core_clk);
    check("core_reset", core_reset, 1'b1);
  endtask : t_wait_reset
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    mode_sel = 2'h0;
    halt_req = 1'b0;
    int_enabled = 1'b1;
    wait_cycle = 1'b0;
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    check("after_reset", {halted, sys_clk_en, osc_en}, 3'h3);
    repeat (4) @(negedge core_clk);
    t_idle();
    t_stop();
    t_refuse();
    t_run();
    t_freeze();
    t_wait_reset();
    print_verdict();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule : scrc_ctrl_tb
`default_nettype wire
